/* verif/pilb_mac_model.sv */
// Behavioural MAC-side traffic and receive FIFO event source
`timescale 1ns/1ps
`default_nettype none
module pilb_mac_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_rx_frame,
	input wire logic i_tx_frame,
	input wire logic i_ovf_evt,
	input wire logic i_unf_evt,
	output logic o_rx_act,
	output logic o_tx_act,
	output logic o_ovf,
	output logic o_unf
);
	// ---------------------------------------
	// Traffic and events, launched just after the edge
	// ---------------------------------------
	// Events stay one cycle wide, as the block expects pulses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_act <= 1'b0;
			o_tx_act <= 1'b0;
			o_ovf <= 1'b0;
			o_unf <= 1'b0;
		end else begin
			o_rx_act <= i_rx_frame;
			o_tx_act <= i_tx_frame;
			o_ovf <= i_ovf_evt;
			o_unf <= i_unf_evt;
		end
	end
endmodule : pilb_mac_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the interface, LED and self-test registers
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pilb_pkg::*;
	// ---------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------
	logic i_clk, i_rst, wr, rd, rxf, txf, ovfe, unfe, rxa, txa, ovf, unf;
	logic bpass, link, spd, fdx, col, realign, loop, scrx, sctx, rmii, rev;
	logic mdix, fmdix, run, psel, fe, l_spd, l_lnk, l_act, rxp, txp, prev;
	logic [1:0] lp, pp, elast, txsrc, rxport;
	logic [4:0] addr, paddr;
	logic [15:0] wdata, rdata;
	logic s_rmii, s_ext; // Straps, changed only across a reset
	int err_total, check_count, n;
	pilb_mac_model u_mac (.i_clk(i_clk), .i_rst(i_rst), .i_rx_frame(rxf), .i_tx_frame(txf),
		.i_ovf_evt(ovfe), .i_unf_evt(unfe), .o_rx_act(rxa), .o_tx_act(txa), .o_ovf(ovf),
		.o_unf(unf));
	// Short counts keep blink and stretch visible in a brief run
	pilb_ctrl #(.BLINK_HALF(16), .STRETCH_CYC(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_strap_rmii(s_rmii), .i_strap_extender(s_ext),
		.i_strap_led_cfg0(1'b1), .i_strap_mdix(1'b1), .i_strap_addr(5'h05),
		.i_rx_fifo_ovf(ovf), .i_rx_fifo_unf(unf), .i_local_pause(lp), .i_partner_pause(pp),
		.i_bist_pass(bpass), .i_link_up(link), .i_speed_100(spd), .i_full_duplex(fdx),
		.i_tx_act(txa), .i_rx_act(rxa), .i_collision(col),
		.o_tx_latency_realign_disable(realign), .o_remote_line_loopback(loop),
		.o_single_clock_receive_mode(scrx), .o_single_clock_transmit_mode(sctx),
		.o_reduced_mode(rmii), .o_reduced_interface_old_revision(rev),
		.o_elasticity_buffer_setting(elast), .o_tx_source(txsrc), .o_rx_port(rxport),
		.o_auto_crossover_enable(mdix), .o_force_pair_crossover(fmdix),
		.o_self_test_run(run), .o_self_test_sequence_select(psel),
		.o_self_test_force_error(fe), .o_port_management_address(paddr),
		.o_speed_indicator_output(l_spd), .o_link_indicator_output(l_lnk),
		.o_activity_collision_indicator_output(l_act));
	// ---------------------------------------
	// Clock, watchdog and shared tasks
	// ---------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// Whole run is about 530 cycles; far beyond that means a hang
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		print_verdict();
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One-cycle strobe, launched and dropped on falling edges
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge i_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_clk);
		wr = 1'b0;
	endtask : reg_wr
	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge i_clk);
		addr = a;
		rd = 1'b1;
		@(negedge i_clk);
		rd = 1'b0;
		chk(rdata, e);
	endtask : reg_rd
	task automatic idle(input int c);
		repeat (c) @(negedge i_clk);
	endtask : idle
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// ---------------------------------------
	// Main sequence
	// ---------------------------------------
	initial begin
		{i_rst, addr, wdata, wr, rd, rxf, txf, ovfe, unfe} = {1'b1, 27'h0};
		{s_rmii, s_ext} = 2'b01;
		{bpass, link, spd, fdx, col, lp, pp} = 9'h000;
		idle(6);
		i_rst = 1'b0;
		// Straps need three edges to land
		idle(6);
		reg_rd(5'h17, 16'h04C1);
		reg_rd(5'h18, 16'h0000);
		reg_rd(5'h19, 16'h8025);
		reg_rd(5'h1A, 16'h0000);
		reg_wr(5'h1A, 16'hFFFF);
		reg_rd(5'h17, 16'h04C1);
		// Reduced mode blocks both single-clock bits
		reg_wr(5'h17, 16'h21FF);
		reg_rd(5'h17, 16'h2133);
		chk(16'({realign, loop, scrx, sctx, rmii, rev, elast}), 16'h00CF);
		reg_wr(5'h17, 16'h1EC0);
		reg_rd(5'h17, 16'h1EC0);
		chk(16'({txsrc, rxport, scrx, sctx, rmii}), 16'h007E);
		// Sticky FIFO flags, cleared by the read that shows them
		for (int i = 0; i < 2; i++) begin
			@(negedge i_clk);
			{ovfe, unfe} = (i == 0) ? 2'b10 : 2'b01;
			@(negedge i_clk);
			{ovfe, unfe} = 2'b00;
			idle(3);
			reg_rd(5'h17, (i == 0) ? 16'h1EC8 : 16'h1EC4);
			reg_rd(5'h17, 16'h1EC0);
		end
		reg_wr(5'h18, 16'hFFFF);
		reg_rd(5'h18, 16'h01FF);
		idle(2);
		chk(16'({l_spd, l_lnk, l_act}), 16'h0007);
		reg_wr(5'h18, 16'h0038);
		idle(2);
		chk(16'({l_spd, l_lnk, l_act}), 16'h0000);
		reg_wr(5'h18, 16'h0000);
		// Mode 1 with stretching bypassed
		reg_wr(5'h19, 16'h80A5);
		{link, spd, rxf} = 3'b111;
		idle(4);
		chk(16'({l_spd, l_lnk, l_act}), 16'h0007);
		rxf = 1'b0;
		idle(3);
		chk(16'(l_act), 16'h0000);
		txf = 1'b1;
		reg_wr(5'h18, 16'h0100);
		idle(4);
		chk(16'(l_act), 16'h0000);
		reg_wr(5'h18, 16'h0000);
		idle(4);
		chk(16'(l_act), 16'h0001);
		txf = 1'b0;
		// Stretching holds a short burst on
		reg_wr(5'h19, 16'h8025);
		idle(4);
		rxf = 1'b1;
		idle(2);
		rxf = 1'b0;
		idle(3);
		chk(16'(l_act), 16'h0001);
		idle(12);
		chk(16'(l_act), 16'h0000);
		// Mode 0: collision on shared LED, Link_indicator_output blinks on activity
		reg_wr(5'h19, 16'h8005);
		col = 1'b1;
		idle(4);
		chk(16'(l_act), 16'h0001);
		col = 1'b0;
		rxf = 1'b1;
		for (int s = 0; s < 4; s++) begin
			reg_wr(5'h18, 16'(s << 6));
			idle(4);
			n = 0;
			prev = l_lnk;
			repeat (64) begin
				@(negedge i_clk);
				n += (l_lnk !== prev) ? 1 : 0;
				prev = l_lnk;
			end
			chk(16'(n >= (4 << s) - 1 && n <= (4 << s) + 1), 16'h0001);
		end
		rxf = 1'b0;
		idle(12);
		chk(16'(l_act), 16'h0000);
		// Mode 2: shared LED shows full duplex
		reg_wr(5'h19, 16'h8045);
		fdx = 1'b1;
		idle(4);
		chk(16'(l_act), 16'h0001);
		// Write clears auto crossover and sets forced crossover
		reg_wr(5'h19, 16'h4505);
		chk(16'({mdix, fmdix, run, psel, paddr}), 16'h00E5);
		bpass = 1'b1;
		idle(2);
		reg_rd(5'h19, 16'h4705);
		reg_wr(5'h19, 16'h4405);
		idle(1);
		reg_rd(5'h19, 16'h4405);
		reg_wr(5'h19, 16'h4C05);
		chk(16'(fe), 16'h0001);
		@(negedge i_clk);
		chk(16'(fe), 16'h0000);
		reg_rd(5'h19, 16'h4405);
		// Every pause advertisement pairing
		for (int k = 0; k < 16; k++) begin
			{pp, lp} = 4'(k);
			txp = (lp[0] & pp[0]) | (~lp[0] & lp[1] & pp[0] & pp[1]);
			rxp = (lp[0] & pp[0]) | (lp[0] & lp[1] & ~pp[0] & pp[1]);
			idle(3);
			reg_rd(5'h19, 16'h4405 | {2'b00, rxp, txp, 12'h000});
		end
		// Reset again under other straps: plain MII, then reduced mode
		for (int r = 0; r < 2; r++) begin
			@(negedge i_clk);
			{i_rst, s_rmii, s_ext} = {1'b1, r[0], r[0]};
			idle(2);
			i_rst = 1'b0;
			idle(6);
			reg_rd(5'h17, (r == 0) ? 16'h0001 : 16'h0421);
		end
		print_verdict();
	end
endmodule : tb
`default_nettype wire

/* verilog/pilb_ctrl.sv */
// Per-port interface, LED direct and transceiver control registers
`timescale 1ns/1ps
`default_nettype none
`include "pilb_regs.svh"
module pilb_ctrl
	import pilb_pkg::*;
#(
	// Half period of the slowest blink, in cycles
	parameter int BLINK_HALF = `PILB_CLK_HZ / (2 * `PILB_BLINK_BASE_HZ),
	// Activity stretch length, in cycles
	parameter int STRETCH_CYC = (`PILB_CLK_HZ / 1000) * `PILB_STRETCH_MS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port from the management interface
	input wire logic [4:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	// Strap pins, sampled after reset release
	input wire logic i_strap_rmii,
	input wire logic i_strap_extender,
	input wire logic i_strap_led_cfg0,
	input wire logic i_strap_mdix,
	input wire logic [4:0] i_strap_addr,
	// Status from the datapath and negotiation
	input wire logic i_rx_fifo_ovf,
	input wire logic i_rx_fifo_unf,
	input wire logic [1:0] i_local_pause,
	input wire logic [1:0] i_partner_pause,
	input wire logic i_bist_pass,
	input wire logic i_link_up,
	input wire logic i_speed_100,
	input wire logic i_full_duplex,
	input wire logic i_tx_act,
	input wire logic i_rx_act,
	input wire logic i_collision,
	// Controls to the datapath
	output logic o_tx_latency_realign_disable,
	output logic o_remote_line_loopback,
	output logic o_single_clock_receive_mode,
	output logic o_single_clock_transmit_mode,
	output logic o_reduced_mode,
	output logic o_reduced_interface_old_revision,
	output logic [1:0] o_elasticity_buffer_setting,
	output logic [1:0] o_tx_source,
	output logic [1:0] o_rx_port,
	output logic o_auto_crossover_enable,
	output logic o_force_pair_crossover,
	output logic o_self_test_run,
	output logic o_self_test_sequence_select,
	output logic o_self_test_force_error,
	output logic [4:0] o_port_management_address,
	// LED pins
	output logic o_speed_indicator_output,
	output logic o_link_indicator_output,
	output logic o_activity_collision_indicator_output
);
	// ---------------------------------------
	// State
	// ---------------------------------------
	pilb_state_t q;
	pilb_state_t d;
	logic wr_ifc; // Write strobes per register
	logic wr_led;
	logic wr_xcv;
	logic rx_pause; // Resolved pause results
	logic tx_pause;
	logic act; // Activity before stretching
	logic shared_raw; // Shared LED source for mode
	logic shared_on; // After stretch or bypass
	logic link_on;
	logic [21:0] half;
	logic sc_rmii; // Reduced mode after this write
	// ---------------------------------------
	// Pause resolution
	// ---------------------------------------
	// Bit 0 is symmetric pause, bit 1 asymmetric
	always_comb begin
		rx_pause = 1'b0;
		tx_pause = 1'b0;
		if (i_local_pause[0] && i_partner_pause[0]) begin
			rx_pause = 1'b1;
			tx_pause = 1'b1;
		end else if (i_local_pause == 2'h2 && i_partner_pause == 2'h3) begin
			tx_pause = 1'b1;
		end else if (i_local_pause == 2'h3 && i_partner_pause == 2'h2) begin
			rx_pause = 1'b1;
		end
	end
	// ---------------------------------------
	// Next state
	// ---------------------------------------
	always_comb begin
		d = q;
		wr_ifc = i_reg_wr && i_reg_addr == `PILB_OFF_IFC;
		wr_led = i_reg_wr && i_reg_addr == `PILB_OFF_LED;
		wr_xcv = i_reg_wr && i_reg_addr == `PILB_OFF_XCV;
		// Two-stage strap synchroniser
		d.strap_m = {i_strap_addr, i_strap_mdix, i_strap_led_cfg0,
			i_strap_extender, i_strap_rmii};
		d.strap_s = q.strap_m;
		// Age marks when both stages hold pin values, so the
		// straps never latch the reset zeros of the synchroniser
		d.strap_age = {q.strap_age[0], 1'b1};
		// Straps land once, the cycle after they settle
		if (!q.strap_done && q.strap_age[1]) begin
			d.strap_done = 1'b1;
			d.rmii = q.strap_s[0];
			d.scrx = q.strap_s[1] && !q.strap_s[0];
			d.sctx = q.strap_s[1] && !q.strap_s[0];
			d.tx_src = q.strap_s[1] ? `PILB_TXSRC_EXT : 2'h0;
			d.led_cfg = {1'b0, q.strap_s[2]};
			d.auto_crossover_enable = q.strap_s[3];
			d.addr = q.strap_s[8:4];
		end
		// Interface register write
		sc_rmii = i_reg_wdata[`PILB_IFC_RMII];
		if (wr_ifc) begin
			d.realign_dis = i_reg_wdata[`PILB_IFC_REALIGN_DIS];
			d.rx_port = i_reg_wdata[12:11];
			d.tx_src = i_reg_wdata[10:9];
			d.loop = i_reg_wdata[`PILB_IFC_LOOP];
			d.rmii = sc_rmii;
			d.rev10 = i_reg_wdata[`PILB_IFC_REV10];
			d.elast = i_reg_wdata[1:0];
			// Reduced mode blocks setting either bit
			d.scrx = sc_rmii ? 1'b0 : i_reg_wdata[`PILB_IFC_SCRX];
			d.sctx = sc_rmii ? 1'b0 : i_reg_wdata[`PILB_IFC_SCTX];
		end
		// LED register write
		if (wr_led) begin
			d.act_rx = i_reg_wdata[`PILB_LED_ACTRX];
			d.blink_sel = i_reg_wdata[7:6];
			d.ovr = i_reg_wdata[5:3];
			d.val = i_reg_wdata[2:0];
		end
		// Force-error lasts exactly one cycle
		d.self_test_force_error = 1'b0;
		if (wr_xcv) begin
			d.auto_crossover_enable = i_reg_wdata[`PILB_XCV_MDIX];
			d.force_pair_crossover = i_reg_wdata[`PILB_XCV_FMDIX];
			d.self_test_force_error = i_reg_wdata[`PILB_XCV_FE];
			d.prbs15 = i_reg_wdata[`PILB_XCV_PRBS];
			d.bist_run = i_reg_wdata[`PILB_XCV_RUN];
			d.bypass = i_reg_wdata[`PILB_XCV_BYP];
			d.led_cfg = i_reg_wdata[6:5];
			d.addr = i_reg_wdata[4:0];
		end
		// Self-test result latches pass, clears when stopped
		if (!q.bist_run) begin
			d.bist_ok = 1'b0;
		end else if (i_bist_pass) begin
			d.bist_ok = 1'b1;
		end
		// Read data, one cycle after the strobe
		d.rdata = 16'h0000;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`PILB_OFF_IFC: begin
					d.rdata = {2'h0, q.realign_dis, q.rx_port, q.tx_src,
						q.loop, q.scrx, q.sctx, q.rmii, q.rev10,
						q.ovf, q.unf, q.elast};
				end
				`PILB_OFF_LED: begin
					d.rdata = {7'h00, q.act_rx, q.blink_sel, q.ovr, q.val};
				end
				`PILB_OFF_XCV: begin
					d.rdata = {q.auto_crossover_enable, q.force_pair_crossover, rx_pause, tx_pause,
						q.self_test_force_error, q.prbs15, q.bist_ok, q.bist_run,
						q.bypass, q.led_cfg, q.addr};
				end
				default: begin
					d.rdata = 16'h0000; // Unmapped reads zero
				end
			endcase
		end
		// Flags clear on a read of the interface register,
		// but a new event in that cycle wins
		if (i_reg_rd && i_reg_addr == `PILB_OFF_IFC) begin
			d.ovf = 1'b0;
			d.unf = 1'b0;
		end
		if (i_rx_fifo_ovf) begin
			d.ovf = 1'b1;
		end
		if (i_rx_fifo_unf) begin
			d.unf = 1'b1;
		end
		// Blink timebase: half period halves per step
		half = 22'(BLINK_HALF >> q.blink_sel);
		if (q.blink_cnt >= half - 22'h000001) begin
			d.blink_cnt = 22'h000000;
			d.blink_ph = !q.blink_ph;
		end else begin
			d.blink_cnt = q.blink_cnt + 22'h000001;
		end
		// Activity source select
		act = i_rx_act || (i_tx_act && !q.act_rx);
		// Shared LED source per mode
		case (q.led_cfg)
			2'h0: shared_raw = i_collision;
			2'h2: shared_raw = i_full_duplex;
			default: shared_raw = act;
		endcase
		// Stretch events so short bursts stay visible
		if (shared_raw) begin
			d.str_cnt = 22'(STRETCH_CYC);
		end else if (q.str_cnt != 22'h000000) begin
			d.str_cnt = q.str_cnt - 22'h000001;
		end
		shared_on = q.bypass ? shared_raw : (shared_raw || q.str_cnt != 22'h000000);
		// Link blinks on activity in modes 0 and 2
		if (q.led_cfg[0]) begin
			link_on = i_link_up;
		end else begin
			link_on = i_link_up && !(act && q.blink_ph);
		end
		// Overrides take the value bits
		d.led[2] = q.ovr[2] ? q.val[2] : i_speed_100;
		d.led[1] = q.ovr[1] ? q.val[1] : link_on;
		d.led[0] = q.ovr[0] ? q.val[0] : shared_on;
	end
	// ---------------------------------------
	// State register
	// ---------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
			q.elast <= `PILB_ELAST_RST;
		end else begin
			q <= d;
		end
	end
	// ---------------------------------------
	// Outputs
	// ---------------------------------------
	assign o_reg_rdata = q.rdata;
	assign o_tx_latency_realign_disable = q.realign_dis;
	assign o_remote_line_loopback = q.loop;
	assign o_single_clock_receive_mode = q.scrx;
	assign o_single_clock_transmit_mode = q.sctx;
	assign o_reduced_mode = q.rmii;
	assign o_reduced_interface_old_revision = q.rev10;
	assign o_elasticity_buffer_setting = q.elast;
	assign o_tx_source = q.tx_src;
	assign o_rx_port = q.rx_port;
	assign o_auto_crossover_enable = q.auto_crossover_enable;
	assign o_force_pair_crossover = q.force_pair_crossover;
	assign o_self_test_run = q.bist_run;
	assign o_self_test_sequence_select = q.prbs15;
	assign o_self_test_force_error = q.self_test_force_error;
	assign o_port_management_address = q.addr;
	assign o_speed_indicator_output = q.led[2];
	assign o_link_indicator_output = q.led[1];
	assign o_activity_collision_indicator_output = q.led[0];
	// ---------------------------------------
	// Assertions
	// ---------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_fe_once;
		o_self_test_force_error |=> !o_self_test_force_error;
	endproperty
	a_fe_once: assert property (p_fe_once) else $error("force error held");
	property p_sc_block;
		wr_ifc && i_reg_wdata[`PILB_IFC_RMII]
			|=> !o_single_clock_receive_mode && !o_single_clock_transmit_mode;
	endproperty
	a_sc_block: assert property (p_sc_block) else $error("single clock set in reduced");
	property p_strap_sc;
		$rose(q.strap_done) && q.strap_s[1] && !q.strap_s[0]
			|-> o_single_clock_receive_mode && o_single_clock_transmit_mode;
	endproperty
	a_strap_sc: assert property (p_strap_sc) else $error("strap single clock lost");
	// Without the extender strap, or with reduced mode strapped,
	// both single-clock bits must come up clear
	property p_strap_plain;
		$rose(q.strap_done) && !(q.strap_s[1] && !q.strap_s[0])
			|-> !o_single_clock_receive_mode && !o_single_clock_transmit_mode;
	endproperty
	a_strap_plain: assert property (p_strap_plain) else $error("strap clock mode wrong");
	property p_strap_src;
		$rose(q.strap_done) |-> o_tx_source == (q.strap_s[1] ? `PILB_TXSRC_EXT : 2'h0);
	endproperty
	a_strap_src: assert property (p_strap_src) else $error("tx source strap lost");
	property p_bist_clr;
		!o_self_test_run |=> !q.bist_ok;
	endproperty
	a_bist_clr: assert property (p_bist_clr) else $error("result not cleared");
	property p_ovr_speed;
		q.ovr[2] |=> o_speed_indicator_output == $past(q.val[2]);
	endproperty
	a_ovr_speed: assert property (p_ovr_speed) else $error("speed override ignored");
	property p_pause_both;
		i_reg_rd && i_reg_addr == `PILB_OFF_XCV && i_local_pause[0]
			&& i_partner_pause[0] |=> o_reg_rdata[13] && o_reg_rdata[12];
	endproperty
	a_pause_both: assert property (p_pause_both) else $error("pause not resolved");
	property p_ovf_flag;
		i_rx_fifo_ovf ##1 (i_reg_rd && i_reg_addr == `PILB_OFF_IFC)
			|=> o_reg_rdata[`PILB_IFC_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag lost");
	property p_bypass;
		q.bypass && q.led_cfg == 2'h1 && !q.ovr[0] && i_rx_act
			|=> o_activity_collision_indicator_output;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass activity missing");
	property p_txonly;
		q.act_rx && q.bypass && q.led_cfg == 2'h1 && !q.ovr[0]
			&& i_tx_act && !i_rx_act |=> !o_activity_collision_indicator_output;
	endproperty
	a_txonly: assert property (p_txonly) else $error("tx shown as activity");
	c_loop: cover property (wr_ifc ##1 o_remote_line_loopback);
	c_strap: cover property ($rose(q.strap_done) && q.strap_s[0]);
	c_bist: cover property (o_self_test_run ##[1:20] q.bist_ok);
	c_ovr: cover property (wr_led && i_reg_wdata[4] ##2 o_link_indicator_output);
endmodule : pilb_ctrl
`default_nettype wire

/* verilog/pilb_pkg.sv */
// Types for the port interface, LED and self-test control block
package pilb_pkg;
	// Whole state of the control block
	typedef struct packed {
		logic [8:0] strap_m;
		logic [8:0] strap_s;
		logic strap_done;
		logic [1:0] strap_age; // Synchroniser fill marks
		logic realign_dis;
		logic [1:0] rx_port;
		logic [1:0] tx_src;
		logic loop;
		logic scrx;
		logic sctx;
		logic rmii;
		logic rev10;
		logic ovf;
		logic unf;
		logic [1:0] elast;
		logic act_rx;
		logic [1:0] blink_sel;
		logic [2:0] ovr;
		logic [2:0] val;
		logic auto_crossover_enable;
		logic force_pair_crossover;
		logic self_test_force_error;
		logic prbs15;
		logic bist_ok;
		logic bist_run;
		logic bypass;
		logic [1:0] led_cfg;
		logic [4:0] addr;
		logic [15:0] rdata;
		logic [21:0] blink_cnt;
		logic blink_ph;
		logic [21:0] str_cnt;
		logic [2:0] led;
	} pilb_state_t;
endpackage : pilb_pkg

/* verilog/pilb_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PILB_REGS_SVH
`define PILB_REGS_SVH
// ---------------------------------------
// Register offsets (management address)
// ---------------------------------------
`define PILB_OFF_IFC 5'h17
`define PILB_OFF_LED 5'h18
`define PILB_OFF_XCV 5'h19
// ---------------------------------------
// Interface register bits
// ---------------------------------------
`define PILB_IFC_REALIGN_DIS 13
`define PILB_IFC_LOOP 8
`define PILB_IFC_SCRX 7
`define PILB_IFC_SCTX 6
`define PILB_IFC_RMII 5
`define PILB_IFC_REV10 4
`define PILB_IFC_OVF 3
`define PILB_IFC_UNF 2
`define PILB_ELAST_RST 2'h1
`define PILB_TXSRC_EXT 2'h2
// ---------------------------------------
// LED register bits
// ---------------------------------------
`define PILB_LED_ACTRX 8
// ---------------------------------------
// Transceiver register bits
// ---------------------------------------
`define PILB_XCV_MDIX 15
`define PILB_XCV_FMDIX 14
`define PILB_XCV_PRX 13
`define PILB_XCV_PTX 12
`define PILB_XCV_FE 11
`define PILB_XCV_PRBS 10
`define PILB_XCV_OK 9
`define PILB_XCV_RUN 8
`define PILB_XCV_BYP 7
// ---------------------------------------
// Timing
// ---------------------------------------
`define PILB_CLK_HZ 40000000
`define PILB_BLINK_BASE_HZ 6
`define PILB_STRETCH_MS 50
`endif
